// [hdl/wdt_trap.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_trap_cfg.svh"

module wdt_trap
	import wdt_trap_pkg::*;
#(
	parameter int          FC_TAP_SHIFT = 23,
	parameter int          FS_TAP_SHIFT = 15,
	parameter logic [15:0] SFR_BASE     = 16'h0000,
	parameter logic [15:0] SFR_TOP      = 16'h003f,
	parameter logic [15:0] RAM_BASE     = 16'h0040,
	parameter logic [15:0] RAM_TOP      = 16'h083f
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        fetch_valid,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        fs_tick,
	output logic             wd_interrupt_request,
	output logic             addr_trap_interrupt,
	output logic             reset_pin_n,
	output logic             osc_restart
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Inclusive address window test, shared by both trap areas
	function automatic logic in_range(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// ------------------------------------------------------------
	// Bus address phase capture
	// ------------------------------------------------------------

	logic       dp_valid;             // Data phase of a taken transfer
	logic       dp_write;             // That transfer is a write
	logic [7:0] dp_addr;              // Its low address byte

	wire logic       take;            // Transfer accepted this edge
	wire logic [7:0] wdata;           // Written byte
	wire logic       wr_ctl;          // Write to control register one
	wire logic       wr_code;         // Write to code register
	wire logic       wr_mode;         // Write to mode register

	assign take    = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];
	assign wdata   = hwdata[7:0];
	assign wr_ctl  = dp_valid && dp_write
		&& (dp_addr == `OFS_CONTROL_ONE);
	assign wr_code = dp_valid && dp_write && (dp_addr == `OFS_CODE);
	assign wr_mode = dp_valid && dp_write && (dp_addr == `OFS_MODE);

	// Only a whole-word transfer is expected, so hsize is not used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'h0;
			dp_write <= 1'h0;
			dp_addr  <= 8'h00;
		end else begin
			dp_valid <= take;
			dp_write <= hwrite;
			dp_addr  <= haddr[7:0];
		end
	end

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------

	logic         wd_enable_bit;          // Software enable bit
	logic [1:0]   wd_detect_time_field;   // Overflow period code
	logic         wd_output_select;       // One: reset, zero: interrupt
	logic         trap_action_select;     // One: reset, zero: interrupt
	logic         ram_trap_stage;         // Written, not yet committed
	logic         ram_trap_select;        // Committed RAM trap enable
	logic         wd_running;             // Watchdog not disabled
	disable_seq_t seq;                    // Disable sequence progress
	logic         mode_hold;              // Stop, idle or sleep active
	logic         mode_slow;              // Slow clock mode
	logic         divider_clock_select;   // Low clock feeds divider

	wire logic busy;                      // Internal reset in progress
	wire logic code_clear;
	wire logic code_disable;
	wire logic code_commit;

	assign busy         = !reset_pin_n;
	assign code_clear   = wr_code && (wdata == `CODE_CLEAR);
	assign code_disable = wr_code && (wdata == `CODE_DISABLE);
	assign code_commit  = wr_code && (wdata == `CODE_TRAP_COMMIT);

	// Reset values also return while the block drives reset out,
	// since that reset initialises the internal hardware as well
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_enable_bit        <= `RST_WD_ENABLE;
			wd_detect_time_field <= `RST_DTIME;
			wd_output_select     <= `RST_OUT_SELECT;
			trap_action_select   <= `RST_TRAP_ACTION;
			ram_trap_stage       <= `RST_RAM_TRAP;
			ram_trap_select      <= `RST_RAM_TRAP;
			wd_running           <= 1'h1;
			mode_hold            <= 1'h0;
			mode_slow            <= 1'h0;
			divider_clock_select <= 1'h0;
		end else if (busy) begin
			wd_enable_bit        <= `RST_WD_ENABLE;
			wd_detect_time_field <= `RST_DTIME;
			wd_output_select     <= `RST_OUT_SELECT;
			trap_action_select   <= `RST_TRAP_ACTION;
			ram_trap_stage       <= `RST_RAM_TRAP;
			ram_trap_select      <= `RST_RAM_TRAP;
			wd_running           <= 1'h1;
			mode_hold            <= 1'h0;
			mode_slow            <= 1'h0;
			divider_clock_select <= 1'h0;
		end else begin
			// One write updates watchdog and trap fields together
			if (wr_ctl) begin
				wd_enable_bit        <= wdata[`BIT_WD_ENABLE];
				wd_detect_time_field <=
					wdata[`BIT_DTIME_HI:`BIT_DTIME_LO];
				// Once at zero it stays there until reset
				wd_output_select     <= wd_output_select
					&& wdata[`BIT_OUT_SELECT];
				trap_action_select   <= wdata[`BIT_TRAP_ACTION];
				ram_trap_stage       <= wdata[`BIT_RAM_TRAP];
				if (wdata[`BIT_WD_ENABLE]) begin
					wd_running <= 1'h1;
				end
			end
			// Staged trap select goes live only on the commit code
			if (code_commit) begin
				ram_trap_select <= ram_trap_stage;
			end
			// Disable accepted only at the end of the full sequence
			if (code_disable && (seq == SEQ_ARMED)
				&& !wd_enable_bit) begin
				wd_running <= 1'h0;
			end
			if (wr_mode) begin
				mode_hold            <= wdata[`BIT_MODE_HOLD];
				mode_slow            <= wdata[`BIT_MODE_SLOW];
				divider_clock_select <= wdata[`BIT_MODE_DIVSEL];
			end
		end
	end

	// ------------------------------------------------------------
	// Disable sequence tracker
	// ------------------------------------------------------------

	// A step out of order falls back to the start, except a clear (restarts at step one) and a repeated control write (stays armed)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq <= SEQ_IDLE;
		end else if (busy) begin
			seq <= SEQ_IDLE;
		end else if (code_clear) begin
			seq <= SEQ_CLEARED;
		end else if (wr_code) begin
			seq <= SEQ_IDLE;
		end else if (wr_ctl) begin
			if ((seq != SEQ_IDLE) && !wdata[`BIT_WD_ENABLE]) begin
				seq <= SEQ_ARMED;
			end else begin
				seq <= SEQ_IDLE;
			end
		end
	end

	// ------------------------------------------------------------
	// Divider and binary counter
	// ------------------------------------------------------------

	wire logic       wd_overflow;     // One-cycle overflow event
	wire logic [1:0] wd_count;        // Binary counter value

	wd_counter #(
		.FC_SHIFT (FC_TAP_SHIFT),
		.FS_SHIFT (FS_TAP_SHIFT)
	) u_counter (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.clear    (busy || code_clear),
		.run      (wd_running),
		.hold     (mode_hold),
		.slow_sel (mode_slow || divider_clock_select),
		.fs_tick  (fs_tick),
		.dtime    (wd_detect_time_field),
		.overflow (wd_overflow),
		.count    (wd_count)
	);

	// ------------------------------------------------------------
	// Address trap detection
	// ------------------------------------------------------------

	wire logic trap_hit;              // Fetch from a guarded area

	assign trap_hit = fetch_valid
		&& (in_range(fetch_addr, SFR_BASE, SFR_TOP)
		|| (ram_trap_select
		&& in_range(fetch_addr, RAM_BASE, RAM_TOP)));

	// ------------------------------------------------------------
	// Event routing
	// ------------------------------------------------------------

	wire logic start_reset;           // Either source asks for reset

	assign start_reset = !busy
		&& ((wd_overflow && wd_output_select)
		|| (trap_hit && trap_action_select));

	// Requests are raw pulses with no mask and no in-service
	// blocking, so a new one reaches the core next cycle unless internal reset is active
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_interrupt_request <= 1'h0;
			addr_trap_interrupt  <= 1'h0;
			osc_restart          <= 1'h0;
		end else begin
			wd_interrupt_request <= !busy && wd_overflow
				&& !wd_output_select;
			addr_trap_interrupt  <= !busy && trap_hit
				&& !trap_action_select;
			osc_restart          <= !busy && trap_hit
				&& trap_action_select && mode_slow;
		end
	end

	// ------------------------------------------------------------
	// Reset pin sequencer
	// ------------------------------------------------------------

	logic [`RESET_CNT_W-1:0] reset_left;  // Cycles of reset remaining

	// Pin held low for the longest allowed reset, then released
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_left  <= '0;
			reset_pin_n <= 1'h1;
		end else if (start_reset) begin
			reset_left  <= `RESET_CNT_W'(`RESET_CYCLES);
			reset_pin_n <= 1'h0;
		end else if (reset_left != '0) begin
			reset_left  <= reset_left - `RESET_CNT_W'(1);
			if (reset_left == `RESET_CNT_W'(1)) begin
				reset_pin_n <= 1'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	wire logic [31:0] status_word;    // Live state for software
	wire logic [31:0] mode_word;      // Mode register read-back
	wire logic [31:0] read_mux;       // Selected read data

	assign status_word = {20'h00000, seq, wd_running, wd_enable_bit,
		ram_trap_stage, ram_trap_select, trap_action_select,
		wd_output_select, wd_detect_time_field, wd_count};
	assign mode_word   = {29'h00000000, divider_clock_select,
		mode_slow, mode_hold};
	// Control and code registers are write-only and read as zero
	assign read_mux = (haddr[7:0] == `OFS_STATUS) ? status_word
		: (haddr[7:0] == `OFS_MODE) ? mode_word : 32'h00000000;

	// Zero wait states; read data sampled at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'h1;
			hresp     <= 1'h0;
		end else begin
			hrdata    <= (take && !hwrite) ? read_mux : 32'h00000000;
			hreadyout <= 1'h1;
			hresp     <= 1'h0;
		end
	end

endmodule

`default_nettype wire

// [hdl/wdt_trap_cfg.svh]
`ifndef WDT_TRAP_CFG_SVH
`define WDT_TRAP_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets (low address byte is decoded)
// ------------------------------------------------------------
`define OFS_CONTROL_ONE   8'h34
`define OFS_CODE          8'h38
`define OFS_STATUS        8'h3c
`define OFS_MODE          8'h40

// ------------------------------------------------------------
// Control register one fields and reset values
// ------------------------------------------------------------
`define BIT_RAM_TRAP      5
`define BIT_TRAP_ACTION   4
`define BIT_WD_ENABLE     3
`define BIT_DTIME_HI      2
`define BIT_DTIME_LO      1
`define BIT_OUT_SELECT    0
`define RST_RAM_TRAP      1'h1
`define RST_TRAP_ACTION   1'h1
`define RST_WD_ENABLE     1'h1
`define RST_DTIME         2'h0
`define RST_OUT_SELECT    1'h1

// ------------------------------------------------------------
// Mode register fields
// ------------------------------------------------------------
`define BIT_MODE_HOLD     0
`define BIT_MODE_SLOW     1
`define BIT_MODE_DIVSEL   2

// ------------------------------------------------------------
// Codes written to the code register
// ------------------------------------------------------------
`define CODE_CLEAR        8'h4e
`define CODE_DISABLE      8'hb1
`define CODE_TRAP_COMMIT  8'hd2

// ------------------------------------------------------------
// Bus and timing
// ------------------------------------------------------------
`define HTRANS_ACTIVE_BIT 1
// Reset output length in high clock periods, the longest allowed
`define RESET_CYCLES      24
`define RESET_CNT_W       9
`define STEP_PER_CODE     2

`endif

// [hdl/wdt_trap_pkg.sv]
package wdt_trap_pkg;

	// Progress through the disable sequence
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_CLEARED,
		SEQ_ARMED
	} disable_seq_t;

endpackage

// [hdl/wd_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_trap_cfg.svh"

module wd_counter #(
	parameter int FC_SHIFT = 23,
	parameter int FS_SHIFT = 15,
	parameter int DIV_W    = FC_SHIFT
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       clear,
	input  wire logic       run,
	input  wire logic       hold,
	input  wire logic       slow_sel,
	input  wire logic       fs_tick,
	input  wire logic [1:0] dtime,
	output logic            overflow,
	output logic [1:0]      count
);

	// ------------------------------------------------------------
	// Divider tap
	// ------------------------------------------------------------

	// True when the low shift bits of the divider are all ones
	function automatic logic tap_hit(input logic [DIV_W-1:0] div,
		input int shift);
		logic [DIV_W-1:0] mask;
		mask = (DIV_W'(1) << shift) - DIV_W'(1);
		return (div & mask) == mask;
	endfunction

	logic [DIV_W-1:0]        div;   // Free running prescaler
	wire logic signed [31:0] shift; // Tap position for current setting
	wire logic               step;  // Divider advances this cycle
	wire logic               tap;   // Quarter-period pulse

	assign shift = (slow_sel ? FS_SHIFT : FC_SHIFT)
		- `STEP_PER_CODE * int'(dtime);
	// Stop, idle and sleep freeze divider and counter
	assign step = !hold && (slow_sel ? fs_tick : 1'b1);
	assign tap  = step && tap_hit(div, shift);

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------

	// Never cleared by the clear code, hence 3/4 minimum period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div <= '0;
		end else if (step) begin
			div <= div + DIV_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Two-stage binary counter
	// ------------------------------------------------------------

	// Held at zero while disabled or cleared; wraps after four taps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count    <= 2'h0;
			overflow <= 1'h0;
		end else begin
			overflow <= run && !clear && tap && (count == 2'h3);
			if (clear || !run) begin
				count <= 2'h0;
			end else if (tap) begin
				count <= count + 2'h1;
			end
		end
	end

endmodule

`default_nettype wire

// [tb/wdt_trap_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the watchdog and trap
// ----------------------------------------
module wdt_trap_sva #(
	parameter logic [15:0] SFR_BASE = 16'h0000,
	parameter logic [15:0] SFR_TOP  = 16'h003f,
	parameter logic [15:0] RAM_TOP  = 16'h083f
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic        wd_interrupt_request,
	input wire logic        addr_trap_interrupt,
	input wire logic        reset_pin_n,
	input wire logic        osc_restart
);
	logic [9:0] low_cnt;   // Cycles the reset output has been low
	wire        sfr_fetch; // Fetch that lands in the register area
	wire        rd_take;   // Read address phase accepted

	assign sfr_fetch = fetch_valid && fetch_addr >= SFR_BASE
		&& fetch_addr <= SFR_TOP;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Length of the reset pulse, cleared once the pin is high
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			low_cnt <= 10'h0;
		else
			low_cnt <= reset_pin_n ? 10'h0 : low_cnt + 10'h1;

	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	zero_wait_a: assert property (hreadyout == 1'b1)
		else $error("slave inserted a wait");
	idle_data_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	sfr_trap_a: assert property (
		sfr_fetch && reset_pin_n |=> addr_trap_interrupt || !reset_pin_n)
		else $error("register area fetch not trapped");
	trap_cause_a: assert property (
		addr_trap_interrupt |-> $past(fetch_valid) && $past(reset_pin_n))
		else $error("trap pulse without fetch");
	far_fetch_a: assert property (
		fetch_valid && fetch_addr > RAM_TOP |=> !addr_trap_interrupt)
		else $error("fetch outside trap areas trapped");
	wd_pulse_a: assert property (
		wd_interrupt_request |=> !wd_interrupt_request)
		else $error("watchdog request longer than one cycle");
	reset_len_a: assert property (
		$rose(reset_pin_n) |-> low_cnt == 10'h018)
		else $error("reset output length wrong");
	reset_cap_a: assert property (low_cnt <= 10'h018)
		else $error("reset output held too long");
	quiet_reset_a: assert property (
		!reset_pin_n && $past(!reset_pin_n)
		|-> !wd_interrupt_request && !addr_trap_interrupt)
		else $error("request during internal reset");
	osc_reset_a: assert property (osc_restart |-> !reset_pin_n)
		else $error("oscillator restart without reset");

	cover property (wd_interrupt_request);
	cover property (addr_trap_interrupt);
	cover property ($fell(reset_pin_n));
	cover property (osc_restart);
endmodule

bind wdt_trap wdt_trap_sva #(
	.SFR_BASE(SFR_BASE),
	.SFR_TOP (SFR_TOP),
	.RAM_TOP (RAM_TOP)
) chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .fetch_valid, .fetch_addr, .wd_interrupt_request,
	.addr_trap_interrupt, .reset_pin_n, .osc_restart);
`default_nettype wire

// [tb/cpu_fetch_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// CPU fetch side and low clock source
// ----------------------------------------
module cpu_fetch_model (
	input  wire logic        hclk,
	input  wire logic        wd_interrupt_request,
	input  wire logic        addr_trap_interrupt,
	output logic             fetch_valid,
	output logic [15:0]      fetch_addr,
	output logic             fs_tick
);
	int         wd_seen   = 0; // Watchdog requests taken
	int         trap_seen = 0; // Trap requests taken
	int         depth     = 0; // Nesting, never unwound
	int         bad_nmi   = 0; // Requests before the stack was set
	logic       stack_ready = 1'b0;
	logic [2:0] div = 3'h0;    // Low clock runs free

	initial begin
		fetch_valid = 1'b0;
		fetch_addr  = 16'hffff;
		fs_tick     = 1'b0;
	end

	// One tick in eight cycles stands in for the slow crystal
	always @(posedge hclk) begin
		div     <= div + 3'h1;
		fs_tick <= (div == 3'h7);
	end

	// No return is ever run, so each cycle with a request nests one deeper
	always @(posedge hclk) begin
		if (wd_interrupt_request === 1'b1 || addr_trap_interrupt === 1'b1)
			depth++;
		if (wd_interrupt_request === 1'b1)
			wd_seen++;
		if (addr_trap_interrupt === 1'b1)
			trap_seen++;
		if ((wd_interrupt_request | addr_trap_interrupt) && !stack_ready)
			bad_nmi++;
	end

	// Fetch for n cycles; a released address shows its inverse
	task automatic fetch(input logic [15:0] a, input int n);
		@(posedge hclk);
		fetch_valid <= 1'b1;
		fetch_addr  <= a;
		repeat (n) @(posedge hclk);
		fetch_valid <= 1'b0;
		fetch_addr  <= ~a;
	endtask
endmodule
`default_nettype wire

// [tb/test_watchdog_with_address_trap.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wdt_trap_cfg.svh"
module test_watchdog_with_address_trap;
	localparam int FC = 8; // Short divider for simulation
	logic        hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, s;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hready, hreadyout, hresp, fetch_valid, fs_tick;
	wire  [31:0] hrdata;
	wire  [15:0] fetch_addr;
	wire         wd_interrupt_request, addr_trap_interrupt;
	wire         reset_pin_n, osc_restart;
	int          cycles = 0, fails = 0, checked = 0, n, w0;

	assign hready = hreadyout; // Single slave drives the bus ready
	wdt_trap #(.FC_TAP_SHIFT(FC), .FS_TAP_SHIFT(8)) dut (.hclk, .hresetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hreadyout, .hresp, .hrdata, .fetch_valid, .fetch_addr, .fs_tick,
		.wd_interrupt_request, .addr_trap_interrupt, .reset_pin_n,
		.osc_restart);
	cpu_fetch_model partner (.hclk, .wd_interrupt_request,
		.addr_trap_interrupt, .fetch_valid, .fetch_addr, .fs_tick);

	// ----------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	// Guards against a hang well past the expected run length
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One AHB single transfer; address then data phase
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	// Cycles until the next watchdog request, bounded
	task automatic wait_wd(output int k);
		k = 0;
		do begin
			@(posedge hclk);
			#1;
			k++;
		end while (wd_interrupt_request !== 1'b1 && k < 3000);
	endtask

	// Cycles until the reset output reaches a level, bounded
	task automatic wait_pin(input logic lvl, output int k);
		k = 0;
		do begin
			@(posedge hclk);
			#1;
			k++;
		end while (reset_pin_n !== lvl && k < 2000);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hresetn = 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`OFS_STATUS, s);
		chk("status", s, 32'h3f0);
		rd(`OFS_CONTROL_ONE, s);
		chk("control", s, 32'h0);
		rd(8'h80, s);
		chk("unmapped", s, 32'h0);
		// Trap reset in slow mode, restarting the oscillator
		wr(`OFS_MODE, 32'h2);
		partner.fetch(16'h0010, 1);
		#1;
		chk("pin", reset_pin_n, 32'h0);
		chk("osc", osc_restart, 32'h1);
		wait_pin(1'b1, n);
		chk("low time", n, 24);
		rd(`OFS_MODE, s);
		chk("mode", s, 32'h0);
		// Interrupt modes and the staged RAM trap select
		partner.stack_ready = 1'b1;
		wr(`OFS_CONTROL_ONE, 32'h0e);
		rd(`OFS_STATUS, s);
		chk("staged", s & 32'hffc, 32'h34c);
		wr(`OFS_CODE, `CODE_TRAP_COMMIT);
		rd(`OFS_STATUS, s);
		chk("live", s & 32'hffc, 32'h30c);
		w0 = partner.trap_seen;
		partner.fetch(16'h0100, 1);
		partner.fetch(16'h0010, 3);
		@(posedge hclk);
		#1;
		chk("traps", partner.trap_seen, w0 + 3);
		chk("no reset", reset_pin_n, 32'h1);
		wr(`OFS_CONTROL_ONE, 32'h2f);
		partner.fetch(16'h0100, 1);
		@(posedge hclk);
		#1;
		chk("uncommitted", partner.trap_seen, w0 + 3);
		wr(`OFS_CODE, `CODE_TRAP_COMMIT);
		partner.fetch(16'h0100, 1);
		@(posedge hclk);
		#1;
		chk("ram trap", partner.trap_seen, w0 + 4);
		rd(`OFS_STATUS, s);
		chk("out select", s[4], 32'h0);
		// Overflow period for every detection code
		for (int d = 0; d < 4; d++) begin
			wr(`OFS_CONTROL_ONE, 32'h28 | (d << 1));
			// Drop a wrap still timed by the old tap before measuring
			wr(`OFS_CODE, `CODE_CLEAR);
			wait_wd(n);
			wait_wd(n);
			chk("period", n, 32'h1 << (FC + 2 - 2 * d));
		end
		// Clearing faster than the period prevents overflow
		wr(`OFS_CODE, `CODE_CLEAR);
		repeat (2) @(posedge hclk);
		w0 = partner.wd_seen;
		repeat (10) wr(`OFS_CODE, `CODE_CLEAR);
		chk("cleared", partner.wd_seen, w0);
		// Pause, then count from the low clock
		wr(`OFS_MODE, 32'h1);
		repeat (2) @(posedge hclk);
		w0 = partner.wd_seen;
		repeat (60) @(posedge hclk);
		chk("held", partner.wd_seen, w0);
		wr(`OFS_MODE, 32'h4);
		wait_wd(n);
		wait_wd(n);
		chk("low period", n, 128);
		wr(`OFS_MODE, 32'h0);
		// Disable only through the ordered codes
		wr(`OFS_CONTROL_ONE, 32'h08);
		wr(`OFS_CODE, `CODE_DISABLE);
		rd(`OFS_STATUS, s);
		chk("running", s[9], 32'h1);
		wr(`OFS_CODE, `CODE_CLEAR);
		rd(`OFS_STATUS, s);
		chk("seq one", s[11:10], 32'h1);
		wr(`OFS_CONTROL_ONE, 32'h00);
		rd(`OFS_STATUS, s);
		chk("seq two", s[11:10], 32'h2);
		wr(`OFS_CODE, `CODE_DISABLE);
		w0 = partner.wd_seen;
		repeat (1100) @(posedge hclk);
		rd(`OFS_STATUS, s);
		chk("stopped", s & 32'h203, 32'h0);
		chk("silent", partner.wd_seen, w0);
		chk("stack", partner.bad_nmi, 0);
		// Second reset: default overflow pulls the pin low
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		wait_pin(1'b0, n);
		chk("overflow", n < 1100, 32'h1);
		wait_pin(1'b1, n);
		chk("reset time", n, 24);
		summarize();
	end
endmodule
`default_nettype wire
